//--- rtl/temp_limit_regs.svh
// Constants of the temperature limit and fault monitor: command codes, field positions,
// reset values and timing. Assumes a command layer that presents decoded command codes.
`ifndef TEMP_LIMIT_REGS_SVH
`define TEMP_LIMIT_REGS_SVH

`define UTL_PAGES 2
`define UTL_CMD_CLEAR_FAULTS 8'h03
`define UTL_CMD_OT_WARN 8'h51
`define UTL_CMD_UT_WARN 8'h52
`define UTL_CMD_UT_FAULT 8'h53
`define UTL_CMD_UT_RESP 8'h54
`define UTL_CMD_STATUS_WORD 8'h79
`define UTL_CMD_STATUS_TEMP 8'h7D

`define UTL_RST_OT_WARN 16'hEB70
`define UTL_RST_UT_WARN 16'hDC40
`define UTL_RST_UT_FAULT 16'hE530
`define UTL_RST_UT_RESP 8'h80
`define UTL_OT_FAULT_LIM 16'hEBE8

`define UTL_OT_WARN_MIN 0
`define UTL_OT_WARN_MAX 175
`define UTL_UT_MIN -55
`define UTL_UT_MAX 25
`define UTL_FRAC 16

`define UTL_ST_OT_FAULT 7
`define UTL_ST_OT_WARN 6
`define UTL_ST_UT_WARN 5
`define UTL_ST_UT_FAULT 4
`define UTL_SW_TEMPERATURE 2
`define UTL_BEH_HI 7
`define UTL_BEH_LO 6
`define UTL_RETRY_HI 5
`define UTL_RETRY_LO 3
`define UTL_BEH_RETRY 2'b10
`define UTL_BEH_HOLD 2'b11
`define UTL_RETRY_NONE 3'b000
`define UTL_RETRY_CONT 3'b111

`define UTL_CLK_HZ 20000000
`define UTL_RETRY_MS 210

`endif

//--- rtl/temp_limit_pkg.sv
// Types of the temperature limit and fault monitor.
// Assumes temp_limit_regs.svh on the include path.
`default_nettype none
`include "temp_limit_regs.svh"

package temp_limit_pkg;

    typedef enum logic [1:0] {
        PG_RUN,
        PG_HOLD,
        PG_RETRY_WAIT,
        PG_LATCHED
    } page_state_e;

    typedef struct packed {
        logic [15:0] ot_warn;
        logic [15:0] ut_warn;
        logic [15:0] ut_fault;
        logic [7:0] ut_resp;
        logic [7:0] stat;
        logic ut_fault_act;
        logic ot_fault_act;
        page_state_e st;
        logic [31:0] cnt;
        logic out_en;
    } page_s;

    typedef struct packed {
        page_s [`UTL_PAGES-1:0] pg;
        logic [15:0] rd_data;
        logic rd_ack;
        logic refused;
        logic alert_oe_n;
        logic alert_lvl;
    } mon_state_s;

endpackage

`default_nettype wire

//--- rtl/temperature_limit_fault_monitor.sv
// Per-page temperature supervision: limits, status, alert and under-temperature response.
// Assumes a command layer that strobes decoded command codes with the selected page, and a
// monitor ADC that delivers each temperature reading as a Linear-11 word with a valid pulse.
`timescale 1ns/10ps
`default_nettype none
`include "temp_limit_regs.svh"

module temperature_limit_fault_monitor #(
    parameter int unsigned RETRY_CYCLES = `UTL_RETRY_MS * (`UTL_CLK_HZ / 1000)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command access
    input wire logic page,
    input wire logic [7:0] cmd_code,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    input wire logic rd_en,
    input wire logic write_protect,
    output logic [15:0] rd_data,
    output logic rd_ack,
    output logic cmd_refused,
    // Temperature measurements
    input wire logic temp_valid,
    input wire logic temp_page,
    input wire logic [15:0] temp_value,
    // Output control
    input wire logic [`UTL_PAGES-1:0] on_cmd,
    input wire logic bias_ok,
    input wire logic [`UTL_PAGES-1:0] other_fault,
    output logic [`UTL_PAGES-1:0] output_enable,
    // Open-drain alert toward the host
    output logic host_alert_output_o,
    output logic host_alert_output_oe_n
);

    temp_limit_pkg::mon_state_s q;
    temp_limit_pkg::mon_state_s nx;

    logic signed [47:0] tfix;
    logic signed [47:0] wfix;
    logic signed [47:0] otw_fix;
    logic signed [47:0] utw_fix;
    logic signed [47:0] utf_fix;
    logic [1:0] beh;
    logic [2:0] retry;
    logic run_ok;
    logic meas;
    logic sel;
    logic hit;
    logic trig;
    logic any_stat;
    logic [7:0] sel_stat;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // Exponent is biased by the fraction width so the shift is never negative
    function automatic logic signed [47:0] lin11_fix(input logic [15:0] v);
        logic signed [47:0] y;
        logic [6:0] sh;
        y = 48'(signed'(v[10:0]));
        sh = {{2{v[15]}}, v[15:11]} + 7'(`UTL_FRAC);
        return y <<< sh[5:0];
    endfunction

    function automatic logic in_range(input logic signed [47:0] f, input int lo, input int hi);
        logic signed [47:0] lo_f;
        logic signed [47:0] hi_f;
        lo_f = 48'(lo) <<< `UTL_FRAC;
        hi_f = 48'(hi) <<< `UTL_FRAC;
        return (f >= lo_f) && (f <= hi_f);
    endfunction

    always_comb begin
        nx = q;
        nx.rd_ack = 1'b0;
        nx.refused = 1'b0;
        tfix = lin11_fix(temp_value);
        wfix = lin11_fix(wr_data);
        otw_fix = '0;
        utw_fix = '0;
        utf_fix = '0;
        beh = '0;
        retry = '0;
        run_ok = 1'b0;
        meas = 1'b0;
        sel = 1'b0;
        hit = 1'b0;
        trig = 1'b0;
        any_stat = 1'b0;
        sel_stat = '0;
        if (wr_en && !(cmd_code inside {`UTL_CMD_CLEAR_FAULTS, `UTL_CMD_OT_WARN,
                `UTL_CMD_UT_WARN, `UTL_CMD_UT_FAULT, `UTL_CMD_UT_RESP})) begin
            nx.refused = 1'b1;
        end
        for (int p = 0; p < `UTL_PAGES; p++) begin
            sel = (page == p[0]);
            meas = temp_valid && (temp_page == p[0]);
            run_ok = on_cmd[p] && bias_ok && !other_fault[p];
            otw_fix = lin11_fix(q.pg[p].ot_warn);
            utw_fix = lin11_fix(q.pg[p].ut_warn);
            utf_fix = lin11_fix(q.pg[p].ut_fault);
            beh = q.pg[p].ut_resp[`UTL_BEH_HI:`UTL_BEH_LO];
            retry = q.pg[p].ut_resp[`UTL_RETRY_HI:`UTL_RETRY_LO];
            hit = 1'b0;
            // Clear goes first so a detection in the same cycle survives it
            if (wr_en && cmd_code == `UTL_CMD_CLEAR_FAULTS) begin
                nx.pg[p].stat = '0;
            end
            // Limit writes are per page; protection and range are checked first
            if (wr_en && sel && cmd_code != `UTL_CMD_CLEAR_FAULTS) begin
                if (write_protect) begin
                    nx.refused = 1'b1;
                end else begin
                    case (cmd_code)
                        `UTL_CMD_OT_WARN: begin
                            if (in_range(wfix, `UTL_OT_WARN_MIN, `UTL_OT_WARN_MAX)) begin
                                nx.pg[p].ot_warn = wr_data;
                            end else begin
                                nx.refused = 1'b1;
                            end
                        end
                        `UTL_CMD_UT_WARN: begin
                            if (in_range(wfix, `UTL_UT_MIN, `UTL_UT_MAX)) begin
                                nx.pg[p].ut_warn = wr_data;
                            end else begin
                                nx.refused = 1'b1;
                            end
                        end
                        `UTL_CMD_UT_FAULT: begin
                            if (in_range(wfix, `UTL_UT_MIN, `UTL_UT_MAX)) begin
                                nx.pg[p].ut_fault = wr_data;
                            end else begin
                                nx.refused = 1'b1;
                            end
                        end
                        `UTL_CMD_UT_RESP: begin
                            nx.pg[p].ut_resp = wr_data[7:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            if (meas) begin
                if (tfix > otw_fix) begin
                    nx.pg[p].stat[`UTL_ST_OT_WARN] = 1'b1;
                end
                if (tfix < utw_fix) begin
                    nx.pg[p].stat[`UTL_ST_UT_WARN] = 1'b1;
                end
                if (tfix > lin11_fix(`UTL_OT_FAULT_LIM)) begin
                    nx.pg[p].ot_fault_act = 1'b1;
                    nx.pg[p].stat[`UTL_ST_OT_FAULT] = 1'b1;
                end else if (tfix < otw_fix) begin
                    nx.pg[p].ot_fault_act = 1'b0;
                end
                if (tfix <= utf_fix) begin
                    nx.pg[p].ut_fault_act = 1'b1;
                    hit = 1'b1;
                end else if (tfix > utw_fix) begin
                    nx.pg[p].ut_fault_act = 1'b0;
                end
            end
            // Codes 00 and 01 of the behaviour field take no action
            trig = hit && beh[1];
            if (trig) begin
                nx.pg[p].stat[`UTL_ST_UT_FAULT] = 1'b1;
            end
            case (q.pg[p].st)
                temp_limit_pkg::PG_RUN: begin
                    if (trig && beh == `UTL_BEH_HOLD) begin
                        nx.pg[p].st = temp_limit_pkg::PG_HOLD;
                    end else if (trig && retry == `UTL_RETRY_CONT) begin
                        nx.pg[p].st = temp_limit_pkg::PG_RETRY_WAIT;
                        nx.pg[p].cnt = '0;
                    end else if (trig) begin
                        // Unused retry codes are treated like no retry
                        nx.pg[p].st = temp_limit_pkg::PG_LATCHED;
                    end
                end
                temp_limit_pkg::PG_HOLD: begin
                    if (!nx.pg[p].ut_fault_act) begin
                        nx.pg[p].st = temp_limit_pkg::PG_RUN;
                    end
                end
                temp_limit_pkg::PG_RETRY_WAIT: begin
                    // Restart is timed only; the fault is not rechecked
                    if (!run_ok) begin
                        nx.pg[p].st = temp_limit_pkg::PG_RUN;
                    end else if (q.pg[p].cnt == 32'(RETRY_CYCLES - 1)) begin
                        nx.pg[p].st = temp_limit_pkg::PG_RUN;
                    end else begin
                        nx.pg[p].cnt = q.pg[p].cnt + 32'h1;
                    end
                end
                temp_limit_pkg::PG_LATCHED: begin
                    nx.pg[p].st = temp_limit_pkg::PG_LATCHED;
                end
                default: begin
                    nx.pg[p].st = temp_limit_pkg::PG_RUN;
                end
            endcase
            nx.pg[p].out_en = run_ok && (nx.pg[p].st == temp_limit_pkg::PG_RUN);
            any_stat = any_stat | (|nx.pg[p].stat);
        end
        nx.alert_oe_n = !any_stat;
        nx.alert_lvl = 1'b0;
        if (rd_en) begin
            nx.rd_ack = 1'b1;
            nx.rd_data = '0;
            sel_stat = q.pg[page].stat;
            case (cmd_code)
                `UTL_CMD_OT_WARN: nx.rd_data = q.pg[page].ot_warn;
                `UTL_CMD_UT_WARN: nx.rd_data = q.pg[page].ut_warn;
                `UTL_CMD_UT_FAULT: nx.rd_data = q.pg[page].ut_fault;
                `UTL_CMD_UT_RESP: nx.rd_data = {8'h00, q.pg[page].ut_resp};
                `UTL_CMD_STATUS_TEMP: nx.rd_data = {8'h00, sel_stat};
                `UTL_CMD_STATUS_WORD: nx.rd_data[`UTL_SW_TEMPERATURE] = |sel_stat;
                default: nx.refused = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int p = 0; p < `UTL_PAGES; p++) begin
                q.pg[p].ot_warn <= `UTL_RST_OT_WARN;
                q.pg[p].ut_warn <= `UTL_RST_UT_WARN;
                q.pg[p].ut_fault <= `UTL_RST_UT_FAULT;
                q.pg[p].ut_resp <= `UTL_RST_UT_RESP;
                q.pg[p].stat <= 8'h00;
                q.pg[p].ut_fault_act <= 1'b0;
                q.pg[p].ot_fault_act <= 1'b0;
                q.pg[p].st <= temp_limit_pkg::PG_RUN;
                q.pg[p].cnt <= 32'h0;
                q.pg[p].out_en <= 1'b0;
            end
            q.rd_data <= 16'h0000;
            q.rd_ack <= 1'b0;
            q.refused <= 1'b0;
            q.alert_oe_n <= 1'b1;
            q.alert_lvl <= 1'b0;
        end else begin
            q <= nx;
        end
    end

    assign rd_data = q.rd_data;
    assign rd_ack = q.rd_ack;
    assign cmd_refused = q.refused;
    assign host_alert_output_o = q.alert_lvl;
    assign host_alert_output_oe_n = q.alert_oe_n;

    generate
        for (genvar g = 0; g < `UTL_PAGES; g++) begin : g_out
            assign output_enable[g] = q.pg[g].out_en;
        end
    endgenerate

    property p_ot_warn_set;
        temp_valid && !temp_page && lin11_fix(temp_value) > lin11_fix(q.pg[0].ot_warn)
            |=> q.pg[0].stat[`UTL_ST_OT_WARN] && !host_alert_output_oe_n;
    endproperty
    a_ot_warn_set: assert property (p_ot_warn_set) else $error("OT warning not raised");

    property p_ut_warn_set;
        temp_valid && !temp_page && lin11_fix(temp_value) < lin11_fix(q.pg[0].ut_warn)
            |=> q.pg[0].stat[`UTL_ST_UT_WARN];
    endproperty
    a_ut_warn_set: assert property (p_ut_warn_set) else $error("UT warning not raised");

    property p_ut_fault_detect;
        temp_valid && !temp_page && lin11_fix(temp_value) <= lin11_fix(q.pg[0].ut_fault)
            |=> q.pg[0].ut_fault_act;
    endproperty
    a_ut_fault_detect: assert property (p_ut_fault_detect) else $error("UT fault missed");

    property p_ut_fault_hyst;
        q.pg[0].ut_fault_act && !(temp_valid && !temp_page
            && lin11_fix(temp_value) > lin11_fix(q.pg[0].ut_warn)) |=> q.pg[0].ut_fault_act;
    endproperty
    a_ut_fault_hyst: assert property (p_ut_fault_hyst)
        else $error("UT fault cleared early");

    // The over-temperature condition only goes away below the warning limit
    property p_ot_fault_hyst;
        q.pg[0].ot_fault_act && !(temp_valid && !temp_page
            && lin11_fix(temp_value) < lin11_fix(q.pg[0].ot_warn)) |=> q.pg[0].ot_fault_act;
    endproperty
    a_ot_fault_hyst: assert property (p_ot_fault_hyst)
        else $error("OT fault cleared early");

    property p_fault_bit_sticky;
        q.pg[0].stat[`UTL_ST_UT_FAULT] && !(wr_en && cmd_code == `UTL_CMD_CLEAR_FAULTS)
            |=> q.pg[0].stat[`UTL_ST_UT_FAULT] && !host_alert_output_oe_n;
    endproperty
    a_fault_bit_sticky: assert property (p_fault_bit_sticky)
        else $error("Fault bit lost");

    // Page 1 carries the continuous retry scenarios
    property p_retry_restart;
        q.pg[1].st == temp_limit_pkg::PG_RETRY_WAIT && q.pg[1].cnt == 32'(RETRY_CYCLES - 1)
            && on_cmd[1] && bias_ok && !other_fault[1] |=> output_enable[1];
    endproperty
    a_retry_restart: assert property (p_retry_restart)
        else $error("Retry did not restart");

    property p_retry_abandon;
        q.pg[1].st == temp_limit_pkg::PG_RETRY_WAIT && !(on_cmd[1] && bias_ok && !other_fault[1])
            |=> q.pg[1].st == temp_limit_pkg::PG_RUN && !output_enable[1];
    endproperty
    a_retry_abandon: assert property (p_retry_abandon)
        else $error("Retry went on after stop");

    property p_latched_off;
        q.pg[0].st == temp_limit_pkg::PG_LATCHED |=> !output_enable[0] [*4];
    endproperty
    a_latched_off: assert property (p_latched_off) else $error("Latched output came on");

    property p_hold_off;
        q.pg[0].st == temp_limit_pkg::PG_HOLD && q.pg[0].ut_fault_act |-> !output_enable[0];
    endproperty
    a_hold_off: assert property (p_hold_off) else $error("Output on during hold");

    property p_wp_blocks;
        wr_en && write_protect && cmd_code == `UTL_CMD_OT_WARN
            |=> $stable(q.pg[0].ot_warn) && cmd_refused;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("Protected write took effect");

    property p_reset_values;
        $past(reset) |-> q.pg[0].ot_warn == `UTL_RST_OT_WARN
            && q.pg[0].ut_warn == `UTL_RST_UT_WARN && q.pg[0].ut_resp == `UTL_RST_UT_RESP;
    endproperty
    a_reset_values: assert property (@(posedge clk) p_reset_values)
        else $error("Bad reset value");

    c_hold: cover property (q.pg[0].st == temp_limit_pkg::PG_HOLD ##1
        q.pg[0].st == temp_limit_pkg::PG_RUN);
    c_retry: cover property (q.pg[0].st == temp_limit_pkg::PG_RETRY_WAIT ##1
        q.pg[0].st == temp_limit_pkg::PG_RUN);
    c_latch: cover property (q.pg[0].st == temp_limit_pkg::PG_LATCHED);
    c_clear: cover property (!host_alert_output_oe_n ##1 host_alert_output_oe_n);

endmodule

`default_nettype wire

//--- tb/host_model.sv
// Host side of the command port: one-cycle read and write strobes, pulled-up alert line.
// Assumes the monitor answers every strobe exactly one clock later.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // Clock
    input wire logic clk,
    // Command strobes
    output logic page,
    output logic [7:0] cmd_code,
    output logic wr_en,
    output logic [15:0] wr_data,
    output logic rd_en,
    input wire logic [15:0] rd_data,
    input wire logic rd_ack,
    input wire logic cmd_refused,
    // Open-drain alert
    input wire logic alert_o,
    input wire logic alert_oe_n,
    output logic alert_line
);
    // Pull-up wins whenever nobody pulls the line down
    assign alert_line = alert_oe_n ? 1'h1 : alert_o;

    initial begin
        page = 1'h0;
        cmd_code = 8'h00;
        wr_en = 1'h0;
        wr_data = 16'h0000;
        rd_en = 1'h0;
    end

    // Released data and code are scrambled so a stale value is never mistaken for a live one
    task automatic xfer(input logic wr, input logic pg, input logic [7:0] code,
                        input logic [15:0] data, output logic [15:0] rdat,
                        output logic ack, output logic refused);
        @(posedge clk);
        page <= pg;
        cmd_code <= code;
        wr_en <= wr;
        rd_en <= !wr;
        wr_data <= data;
        @(posedge clk);
        wr_en <= 1'h0;
        rd_en <= 1'h0;
        wr_data <= ~data;
        cmd_code <= ~code;
        #1;
        rdat = rd_data;
        ack = rd_ack;
        refused = cmd_refused;
    endtask
endmodule

`default_nettype wire

//--- tb/temperature_limit_fault_monitor_test.sv
// Self-checking bench of the temperature limit monitor: limits, status, alert, responses.
// Assumes the host model in host_model.sv and a short retry interval for simulation.
`timescale 1ns/10ps
`default_nettype none
`include "temp_limit_regs.svh"

module temperature_limit_fault_monitor_test;
    localparam int RETRY = 20;
    logic clk = 1'h0;
    logic reset = 1'h1;
    logic write_protect = 1'h0;
    logic temp_valid = 1'h0;
    logic temp_page = 1'h0;
    logic [15:0] temp_value = 16'h0000;
    logic [1:0] on_cmd = 2'h3;
    logic bias_ok = 1'h1;
    logic [1:0] other_fault = 2'h0;
    logic page, wr_en, rd_en, rd_ack, cmd_refused, alert_o, alert_oe_n, alert_line, ack, refd, pg;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data, rv;
    logic [1:0] output_enable, exp_oe;
    int err_count = 0;
    int comparisons = 0;
    int t, sh;
    int corner [8] = '{110, 111, -30, -31, -45, -44, 125, 126};
    logic [7:0] codes [4] = '{`UTL_CMD_OT_WARN, `UTL_CMD_UT_WARN, `UTL_CMD_UT_FAULT,
        `UTL_CMD_UT_RESP};
    logic [15:0] rsts [4] = '{`UTL_RST_OT_WARN, `UTL_RST_UT_WARN, `UTL_RST_UT_FAULT,
        {8'h00, `UTL_RST_UT_RESP}};

    always #25 clk = ~clk;

    temperature_limit_fault_monitor #(.RETRY_CYCLES(RETRY)) i_dut (
        .clk(clk), .reset(reset), .page(page), .cmd_code(cmd_code), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .write_protect(write_protect), .rd_data(rd_data),
        .rd_ack(rd_ack), .cmd_refused(cmd_refused), .temp_valid(temp_valid),
        .temp_page(temp_page), .temp_value(temp_value), .on_cmd(on_cmd), .bias_ok(bias_ok),
        .other_fault(other_fault), .output_enable(output_enable),
        .host_alert_output_o(alert_o), .host_alert_output_oe_n(alert_oe_n));

    host_model i_host (
        .clk(clk), .page(page), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .rd_ack(rd_ack), .cmd_refused(cmd_refused),
        .alert_o(alert_o), .alert_oe_n(alert_oe_n), .alert_line(alert_line));

    task automatic stop_test();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Mantissa scaled by two to the sh, exponent minus sh: same degrees, other encoding
    function automatic logic [15:0] lin(input int deg, input int s);
        return {5'(-s), 11'(deg <<< s)};
    endfunction

    function automatic logic [7:0] stat_exp(input int c);
        return {c > 125, c > 110, c < -30, c <= -45, 4'h0};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic p, input logic [7:0] c, input logic [15:0] d, input logic r);
        i_host.xfer(1'h1, p, c, d, rv, ack, refd);
        check("cmd_refused", {15'h0, refd}, {15'h0, r});
    endtask

    task automatic rd(input logic p, input logic [7:0] c, input logic [15:0] exp);
        i_host.xfer(1'h0, p, c, 16'h0000, rv, ack, refd);
        check("rd_ack", {15'h0, ack}, 16'h0001);
        check("rd_data", rv, exp);
    endtask

    task automatic meas(input logic p, input logic [15:0] v);
        @(posedge clk);
        temp_valid <= 1'h1;
        temp_page <= p;
        temp_value <= v;
        @(posedge clk);
        temp_valid <= 1'h0;
        temp_value <= ~v;
        #1;
    endtask

    task automatic chk_oe(input logic [1:0] exp);
        check("output_enable", {14'h0, output_enable}, {14'h0, exp});
    endtask

    task automatic wait_oe(input logic [1:0] exp, input int max);
        for (int n = 0; n < max && output_enable !== exp; n++)
            cyc(1);
        chk_oe(exp);
        if (output_enable !== exp)
            stop_test();
    endtask

    task automatic do_reset();
        @(posedge clk);
        reset <= 1'h1;
        repeat (6) @(posedge clk);
        reset <= 1'h0;
        cyc(2);
    endtask

    initial begin
        void'($urandom(32'hB26E));
        do_reset();
        for (int p = 0; p < 2; p++)
            for (int k = 0; k < 4; k++)
                rd(p[0], codes[k], rsts[k]);
        chk_oe(2'h3);
        // Corner temperatures first, then random ones in random encodings
        for (int i = 0; i < 24; i++) begin
            t = (i < 8) ? corner[i] : int'($urandom_range(190)) - 60;
            sh = $urandom_range(2);
            pg = 1'($urandom_range(1));
            meas(pg, lin(t, sh));
            rd(pg, `UTL_CMD_STATUS_TEMP, {8'h00, stat_exp(t)});
            rd(pg, `UTL_CMD_STATUS_WORD, {13'h0, |stat_exp(t), 2'h0});
            check("alert_line", {15'h0, alert_line}, {15'h0, ~|stat_exp(t)});
            wr(pg, `UTL_CMD_CLEAR_FAULTS, 16'h0000, 1'h0);
        end
        do_reset();
        wr(1'h1, `UTL_CMD_OT_WARN, lin(175, 0), 1'h0);
        wr(1'h1, `UTL_CMD_OT_WARN, lin(176, 0), 1'h1);
        wr(1'h1, `UTL_CMD_OT_WARN, lin(-1, 2), 1'h1);
        wr(1'h0, `UTL_CMD_UT_WARN, lin(-56, 1), 1'h1);
        wr(1'h0, `UTL_CMD_UT_WARN, lin(25, 1), 1'h0);
        wr(1'h0, `UTL_CMD_UT_FAULT, lin(26, 0), 1'h1);
        wr(1'h0, `UTL_CMD_UT_FAULT, lin(-55, 2), 1'h0);
        rd(1'h1, `UTL_CMD_OT_WARN, lin(175, 0));
        rd(1'h0, `UTL_CMD_OT_WARN, `UTL_RST_OT_WARN);
        rd(1'h0, `UTL_CMD_UT_WARN, lin(25, 1));
        rd(1'h1, `UTL_CMD_UT_FAULT, `UTL_RST_UT_FAULT);
        write_protect <= 1'h1;
        wr(1'h0, `UTL_CMD_UT_RESP, 16'h00C0, 1'h1);
        rd(1'h0, `UTL_CMD_UT_RESP, 16'h0080);
        write_protect <= 1'h0;
        do_reset();
        // Hold-off response on page 0 with hysteresis up to the warning limit
        wr(1'h0, `UTL_CMD_UT_RESP, 16'h00C0, 1'h0);
        meas(1'h0, lin(-45, 0));
        chk_oe(2'h2);
        meas(1'h0, lin(-30, 0));
        cyc(1);
        chk_oe(2'h2);
        meas(1'h0, lin(-29, 1));
        cyc(1);
        chk_oe(2'h3);
        rd(1'h0, `UTL_CMD_STATUS_TEMP, 16'h0030);
        check("alert_line", {15'h0, alert_line}, 16'h0000);
        wr(1'h0, `UTL_CMD_CLEAR_FAULTS, 16'h0000, 1'h0);
        rd(1'h0, `UTL_CMD_STATUS_TEMP, 16'h0000);
        check("alert_line", {15'h0, alert_line}, 16'h0001);
        // Disabled response: warning only, no fault bit, no shutdown
        wr(1'h1, `UTL_CMD_UT_RESP, 16'h0000, 1'h0);
        meas(1'h1, lin(-50, 0));
        chk_oe(2'h3);
        rd(1'h1, `UTL_CMD_STATUS_TEMP, 16'h0020);
        // Continuous retry, then each stop cause abandons the restart
        wr(1'h1, `UTL_CMD_UT_RESP, 16'h00B8, 1'h0);
        for (int k = 0; k < 4; k++) begin
            meas(1'h1, lin(-50, 0));
            chk_oe(2'h1);
            if (k == 0) begin
                cyc(RETRY - 3);
                chk_oe(2'h1);
                wait_oe(2'h3, 8);
            end else begin
                @(posedge clk);
                on_cmd[1] <= (k != 1);
                bias_ok <= (k != 2);
                other_fault[1] <= (k == 3);
                exp_oe = (k == 2) ? 2'h0 : 2'h1;
                // Restore long before the timer ends: only an abandoned wait restarts at once
                cyc(3);
                chk_oe(exp_oe);
                on_cmd <= 2'h3;
                bias_ok <= 1'h1;
                other_fault <= 2'h0;
                wait_oe(2'h3, 4);
            end
        end
        // Latched shutdown survives clear faults and good readings until reset
        wr(1'h0, `UTL_CMD_UT_RESP, 16'h0080, 1'h0);
        meas(1'h0, lin(-45, 2));
        chk_oe(2'h2);
        wr(1'h0, `UTL_CMD_CLEAR_FAULTS, 16'h0000, 1'h0);
        meas(1'h0, lin(20, 0));
        cyc(RETRY + 5);
        chk_oe(2'h2);
        do_reset();
        chk_oe(2'h3);
        stop_test();
    end
endmodule

`default_nettype wire
